/* dsx_defs.vh */
// constants for the decrement and skip execution block
`ifndef DSX_DEFS_VH
`define DSX_DEFS_VH
// opcode upper six bits
`define DSX_OPC_DEC_FILE  6'h01
`define DSX_OPC_DEC_SKIP  6'h0b
// instruction field positions
`define DSX_OPC_HI        15
`define DSX_OPC_LO        10
`define DSX_DEST_BIT      9
`define DSX_ACC_BIT       8
// indexed literal offset limit and access bank split
`define DSX_ILO_LIMIT     8'h5f
`define DSX_ACC_SPLIT     8'h60
`define DSX_SFR_BANK      4'hf
// ahb register byte offsets
`define DSX_REG_INSTR     12'h000
`define DSX_REG_CTRL      12'h004
`define DSX_REG_WREG      12'h008
`define DSX_REG_STATUS    12'h00c
`define DSX_REG_BANK      12'h010
`define DSX_REG_FSR2      12'h014
`define DSX_REG_FILE      12'h018
`define DSX_REG_FDATA     12'h01c
`define DSX_REG_RESULT    12'h020
// status bit positions
`define DSX_ST_C          0
`define DSX_ST_DIGIT      1
`define DSX_ST_Z          2
`define DSX_ST_OVFL       3
`define DSX_ST_N          4
// ctrl bit positions
`define DSX_CTRL_EXT      0
`define DSX_CTRL_TWO      1
// reset values
`define DSX_RST_BYTE      8'h00
`define DSX_RST_INSTR     16'h0000
// quarter phase codes
`define DSX_Q1            2'h0
`define DSX_Q2            2'h1
`define DSX_Q3            2'h2
`define DSX_Q4            2'h3
// idle cycles after a skip, one per discarded word
`define DSX_IDLE_ONE      2'h1
`define DSX_IDLE_TWO      2'h2
`endif

/* dsx_alu.v */
// byte decrement with flag generation
`timescale 1ns/1ps
`include "dsx_defs.vh"
module dsx_alu
(
  // operand
  input  wire [7:0] opnd,
  // result and flags
  output wire [7:0] res,
  output wire [4:0] flags
);
  // subtract one as f + ff; carry means no borrow
  wire [8:0] sum;
  assign sum = {1'b0, opnd} + 9'h0ff;
  assign res = sum[7:0];
  // flag order follows the status layout: negative, overflow, zero, digit carry, carry
  assign flags = {res[7],
                  (opnd == 8'h80),
                  (res == 8'h00),
                  (opnd[3:0] != 4'h0),
                  sum[8]};
endmodule // dsx_alu

/* dsx_core.v */
// decrement and decrement-skip-on-zero execution unit with ahb-lite registers
`timescale 1ns/1ps
`include "dsx_defs.vh"
module dsx_core
(
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // file memory port
  output reg  [11:0] file_addr,
  output reg         file_we,
  output reg  [7:0]  file_wdata,
  // execution state
  output wire        busy,
  output reg  [1:0]  idle_cnt
);

  // ************************************************************
  // bus address phase capture
  // ************************************************************
  reg        wr_pend_q;
  reg [11:0] addr_q;
  wire       take;
  // hsize is not decoded: only single whole-word transfers are expected
  assign take = hsel & hready & htrans[1];
  // zero wait states: every register answers in its data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // latch the address phase for the following data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      if (take)
        addr_q <= haddr[11:0];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  reg [15:0] instr_q;
  reg [1:0]  ctrl_q;
  reg [7:0]  wreg_q;
  reg [4:0]  status_q;
  reg [3:0]  bank_q;
  reg [11:0] fsr2_q;
  reg [7:0]  fdata_q;
  reg [7:0]  result_q;
  // sequencer state
  reg [1:0]  phase_q;
  reg        run_q;
  reg [11:0] ea_q;
  reg        skip_q;

  // ************************************************************
  // instruction decode
  // ************************************************************
  // opcode decode, shared by the stored word and the word being written
  function [1:0] op_kind;
    input [15:0] w;
    begin
      op_kind = {(w[`DSX_OPC_HI:`DSX_OPC_LO] == `DSX_OPC_DEC_SKIP),
                 (w[`DSX_OPC_HI:`DSX_OPC_LO] == `DSX_OPC_DEC_FILE)};
    end
  endfunction

  // instruction fields; instr only changes between operations, so these stay put
  wire       dest;
  wire       acc;
  wire [7:0] f;
  wire [1:0] kind_i;
  wire [1:0] kind_w;
  wire       is_plain;
  wire       is_dsz;
  assign dest     = instr_q[`DSX_DEST_BIT];
  assign acc      = instr_q[`DSX_ACC_BIT];
  assign f        = instr_q[7:0];
  assign kind_i   = op_kind(instr_q);
  assign kind_w   = op_kind(hwdata[15:0]);
  assign is_plain = kind_i[0];
  assign is_dsz   = kind_i[1];
  // busy covers the four quarters and any idle cycles after a skip
  assign busy = run_q | (idle_cnt != 2'h0);

  // effective address of the file operand; the indexed form adds the
  // literal to the index base and may land in any bank
  function [11:0] eff_addr;
    input        a;
    input [7:0]  fa;
    input        ext;
    input [3:0]  bank_sel;
    input [11:0] idx_base;
    begin
      if (a)
        eff_addr = {bank_sel, fa};
      else if (ext && (fa <= `DSX_ILO_LIMIT))
        eff_addr = idx_base + {4'h0, fa};
      else if (fa < `DSX_ACC_SPLIT)
        eff_addr = {4'h0, fa};
      else
        eff_addr = {`DSX_SFR_BANK, fa};
    end
  endfunction

  // ************************************************************
  // arithmetic
  // ************************************************************
  wire [7:0] dec_res;
  wire [4:0] dec_flags;
  dsx_alu u_alu
  (
    .opnd  (fdata_q),
    .res   (dec_res),
    .flags (dec_flags)
  );

  // an operation starts on the data phase of its instruction write; a
  // write while busy or with a foreign opcode starts nothing
  wire launch;
  assign launch = wr_pend_q & (addr_q == `DSX_REG_INSTR) & ~busy
                  & (kind_w != 2'h0);

  // ************************************************************
  // quarter-cycle sequencer: decode, read, process, write
  // ************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q    <= 1'b0;
      phase_q  <= `DSX_Q1;
      ea_q     <= 12'h000;
      result_q <= `DSX_RST_BYTE;
      skip_q   <= 1'b0;
      idle_cnt <= 2'h0;
    end
    // a new operation restarts at the decode quarter and drops the old skip
    else if (launch)
    begin
      run_q   <= 1'b1;
      phase_q <= `DSX_Q1;
      skip_q  <= 1'b0;
    end
    else if (run_q)
    begin
      phase_q <= phase_q + 2'h1;
      case (phase_q)
        // decode quarter: resolve the operand address
        `DSX_Q1: ea_q <= eff_addr(acc, f, ctrl_q[`DSX_CTRL_EXT], bank_q, fsr2_q);
        // read quarter: the operand byte already sits in fdata
        `DSX_Q2: ;
        // process quarter: the result and the skip decision
        `DSX_Q3:
        begin
          result_q <= dec_res;
          skip_q   <= is_dsz & (dec_res == 8'h00);
        end
        // write quarter: the destination is written and the operation ends
        default:
        begin
          run_q <= 1'b0;
          // one idle cycle per discarded word
          if (skip_q)
            idle_cnt <= ctrl_q[`DSX_CTRL_TWO] ? `DSX_IDLE_TWO : `DSX_IDLE_ONE;
        end
      endcase
    end
    // count the discarded words down; busy stays high meanwhile
    else if (idle_cnt != 2'h0)
      idle_cnt <= idle_cnt - 2'h1;
  end

  // ************************************************************
  // file memory port
  // ************************************************************
  // write only in the fourth quarter and only with dest set
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      file_addr  <= 12'h000;
      file_we    <= 1'b0;
      file_wdata <= `DSX_RST_BYTE;
    end
    else
    begin
      file_we <= run_q & (phase_q == `DSX_Q4) & dest;
      // address taken in the read quarter so it holds steady through the write
      if (run_q && phase_q == `DSX_Q2)
        file_addr <= ea_q;
      if (run_q && phase_q == `DSX_Q4)
        file_wdata <= result_q;
    end
  end

  // ************************************************************
  // software registers and destination write
  // ************************************************************
  wire wsel;
  assign wsel = wr_pend_q;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_q  <= `DSX_RST_INSTR;
      ctrl_q   <= 2'h0;
      wreg_q   <= `DSX_RST_BYTE;
      status_q <= 5'h00;
      bank_q   <= 4'h0;
      fsr2_q   <= 12'h000;
      fdata_q  <= `DSX_RST_BYTE;
    end
    else
    begin
      if (wsel && addr_q == `DSX_REG_INSTR && !busy)
        instr_q <= hwdata[15:0];
      if (wsel && addr_q == `DSX_REG_CTRL)
        ctrl_q <= hwdata[1:0];
      // bank, index base and the ext bit of control are sampled at decode only, so a
      // change during an operation takes effect with the next one; the two bit is sampled in the write quarter
      if (wsel && addr_q == `DSX_REG_BANK)
        bank_q <= hwdata[3:0];
      if (wsel && addr_q == `DSX_REG_FSR2)
        fsr2_q <= hwdata[11:0];
      // operand latched by software holds the addressed file byte
      if (wsel && addr_q == `DSX_REG_FDATA && !run_q)
        fdata_q <= hwdata[7:0];
      // hardware update in the fourth quarter beats a software write
      if (run_q && phase_q == `DSX_Q4 && !dest)
        wreg_q <= result_q;
      else if (wsel && addr_q == `DSX_REG_WREG)
        wreg_q <= hwdata[7:0];
      if (run_q && phase_q == `DSX_Q4 && is_plain)
        status_q <= dec_flags;
      else if (wsel && addr_q == `DSX_REG_STATUS)
        status_q <= hwdata[4:0];
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // read mux on the address phase; unmapped addresses read zero
  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h0000_0000;
    if (haddr[11:0] == `DSX_REG_INSTR)
      rd_d = {16'h0000, instr_q};
    else if (haddr[11:0] == `DSX_REG_CTRL)
      rd_d = {30'h0, ctrl_q};
    else if (haddr[11:0] == `DSX_REG_WREG)
      rd_d = {24'h0, wreg_q};
    else if (haddr[11:0] == `DSX_REG_STATUS)
      rd_d = {27'h0, status_q};
    else if (haddr[11:0] == `DSX_REG_BANK)
      rd_d = {28'h0, bank_q};
    else if (haddr[11:0] == `DSX_REG_FSR2)
      rd_d = {20'h0, ea_q};
    else if (haddr[11:0] == `DSX_REG_FILE)
      rd_d = {29'h0, idle_cnt, busy};
    else if (haddr[11:0] == `DSX_REG_FDATA)
      rd_d = {24'h0, fdata_q};
    else if (haddr[11:0] == `DSX_REG_RESULT)
      rd_d = {23'h0, skip_q, result_q};
  end

  // read data comes from a flop; it shows the register state at the
  // address phase edge, so an update in that same edge shows next read
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_d;
    else
      hrdata <= 32'h0000_0000;
  end

endmodule // dsx_core

/* dsx_core_properties.sv */
// port-level checks for the decrement and skip execution unit
`timescale 1ns/1ps
`include "dsx_defs.vh"
// ************
// checker
// ************
module dsx_props
(
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  // execution
  input wire [11:0] file_addr,
  input wire        file_we,
  input wire [7:0]  file_wdata,
  input wire        busy,
  input wire [1:0]  idle_cnt
);
  logic        ap_q;
  logic [11:0] a_q;
  logic [15:0] ins_q;
  logic [7:0]  fd_q;
  logic [3:0]  bk_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow of the last accepted instruction, operand and bank, so writes can be predicted
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q <= 1'b0;
      a_q <= 12'h000;
      ins_q <= 16'h0000;
      fd_q <= 8'h00;
      bk_q <= 4'h0;
    end
    else
    begin
      ap_q <= hsel & hready & htrans[1] & hwrite;
      a_q <= haddr[11:0];
      if (ap_q && a_q == `DSX_REG_INSTR && !busy) ins_q <= hwdata[15:0];
      if (ap_q && a_q == `DSX_REG_FDATA && !busy) fd_q <= hwdata[7:0];
      if (ap_q && a_q == `DSX_REG_BANK) bk_q <= hwdata[3:0];
    end
  end
  AST_WB_DATA: assert property (file_we |-> file_wdata == fd_q - 8'h01)
    else $error("written byte is not operand minus one");
  AST_WB_DEST: assert property (file_we |-> ins_q[9])
    else $error("file written while destination is the working register");
  AST_WE_PULSE: assert property (file_we |=> !file_we)
    else $error("file write strobe longer than one cycle");
  AST_ACC_BANK: assert property (file_we && !ins_q[8] && ins_q[7:0] >= 8'h60
    |-> file_addr == {4'hf, ins_q[7:0]})
    else $error("access bank address wrong");
  AST_BANK_SEL: assert property (file_we && ins_q[8] |-> file_addr == {bk_q, ins_q[7:0]})
    else $error("banked address wrong");
  AST_SKIP_CAUSE: assert property ($past(idle_cnt) == 2'h0 && idle_cnt != 2'h0
    |-> ins_q[15:10] == `DSX_OPC_DEC_SKIP && fd_q == 8'h01)
    else $error("skip without a zero result of the skip opcode");
  AST_IDLE_DEC: assert property (idle_cnt != 2'h0 |-> busy ##1 idle_cnt == $past(idle_cnt) - 2'h1)
    else $error("idle count does not step down under busy");
  AST_BUSY_END: assert property ($fell(busy) |-> idle_cnt == 2'h0 && $past(idle_cnt) != 2'h2)
    else $error("busy dropped with idle cycles left");
endmodule // dsx_props

/* tb_decrement_skip_execution.sv */
// self-checking bench for the decrement and skip execution unit
`timescale 1ns/1ps
`include "dsx_defs.vh"
// ************
// bench
// ************
module tb_decrement_skip_execution;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wseen = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd_v;
  logic [1:0]  htrans = 0;
  logic [7:0]  wd, wexp = 8'h00;
  wire  [31:0] hrdata;
  wire  [11:0] file_addr;
  wire  [7:0]  file_wdata;
  wire  [1:0]  idle_cnt;
  wire         hreadyout, hresp, file_we, busy;
  int          n_fail = 0, samples_checked = 0, bcnt = 0;
  // one clock per quarter: decode, read, process, write
  localparam int QCYC = 4;
  always #20 hclk = ~hclk;
  // hready is the lone slave's own hreadyout
  dsx_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .busy(busy), .idle_cnt(idle_cnt));
  // busy length and file write monitor
  always @(posedge hclk)
  begin
    if (busy === 1'b1) bcnt++;
    if (file_we === 1'b1)
    begin
      wseen = 1;
      wd = file_wdata;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; read data taken at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic run(input logic [15:0] ins, input logic [7:0] fd, input logic [1:0] ct,
    input logic [3:0] bk, input logic [7:0] st, input logic [11:0] fa, input int ex);
    xfer(1, `DSX_REG_FDATA, {24'h0, fd});
    xfer(1, `DSX_REG_CTRL, {30'h0, ct});
    xfer(1, `DSX_REG_BANK, {28'h0, bk});
    bcnt = 0; wseen = 0;
    xfer(1, `DSX_REG_INSTR, {16'h0, ins});
    #1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk(32'(bcnt), 32'(QCYC + ex));
    if (!ins[9]) wexp = fd - 8'h01;
    xfer(0, `DSX_REG_WREG, 0);
    chk(rd_v, {24'h0, wexp});
    xfer(0, `DSX_REG_STATUS, 0);
    chk(rd_v, {24'h0, st});
    chk({31'h0, wseen}, {31'h0, ins[9]});
    if (ins[9]) chk({24'h0, wd}, {24'h0, fd - 8'h01});
    chk({20'h0, file_addr}, {20'h0, fa});
    xfer(0, `DSX_REG_RESULT, 0);
    chk({23'h0, rd_v[8:0]}, {23'h0, ex != 0, fd - 8'h01});
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog sized well past six short instructions
  initial
  begin
    #200000;
    n_fail++;
    final_report;
  end
  // main sequence: plain and skip forms over every bank path
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    xfer(0, 12'h0fc, 0);
    chk(rd_v, 32'h0);
    xfer(1, `DSX_REG_FSR2, 32'h100);
    run(16'h0580, 8'h80, 2'h0, 4'h0, 8'h09, 12'h080, 0);
    run(16'h0670, 8'h10, 2'h0, 4'h0, 8'h01, 12'hf70, 0);
    run(16'h0722, 8'h01, 2'h0, 4'h3, 8'h07, 12'h322, 0);
    run(16'h2e10, 8'h01, 2'h1, 4'h0, 8'h07, 12'h110, 1);
    run(16'h2c30, 8'h00, 2'h0, 4'h0, 8'h07, 12'h030, 0);
    run(16'h2d44, 8'h01, 2'h2, 4'h5, 8'h07, 12'h544, 2);
    final_report;
  end
endmodule // tb_decrement_skip_execution
bind dsx_core dsx_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .file_addr(file_addr),
  .file_we(file_we), .file_wdata(file_wdata), .busy(busy), .idle_cnt(idle_cnt));
